// ==== hdl/scgcf_cmd_if.sv ====
// Command byte hand-off between the serial link side and the core side
`timescale 1ns/100ps
interface scgcf_cmd_if;
   logic [7:0] cmd_byte;
   logic cmd_toggle;

   // Link side produces the byte and flips the toggle on the same edge
   modport link (output cmd_byte, output cmd_toggle);
   modport core (input cmd_byte, input cmd_toggle);
endinterface : scgcf_cmd_if

// ==== hdl/scgcf_cmd_link.sv ====
// Serial link side: captures the first byte of each frame as the command
`timescale 1ns/100ps
module scgcf_cmd_link (
   // Link clock and reset
   input wire logic sclk,
   input wire logic rst_b,
   // Serial pins
   input wire logic cs_in,
   input wire logic sdio_in,
   // Hand-off to the core
   scgcf_cmd_if.link cmd_port
);

   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic frame_rst_b;

   // The link clock stops between frames, so chip select ends the frame itself
   assign frame_rst_b = rst_b & cs_in;

   // Bit counter, stops after the command byte
   always_ff @(posedge sclk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         bit_cnt_ff <= 4'h0;
      end else if (bit_cnt_ff != scgcf_pkg::CMD_BIT_DONE) begin
         bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
   end

   // command first
   // Shift in lsb first, the direction bit arrives last
   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         shift_ff <= 8'h00;
      end else if (bit_cnt_ff != scgcf_pkg::CMD_BIT_DONE) begin
         shift_ff <= {sdio_in, shift_ff[7:1]};
      end
   end

   // Byte and toggle change on the same edge; the core waits for the toggle
   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_port.cmd_byte <= 8'h00;
         cmd_port.cmd_toggle <= 1'b0;
      end else if (bit_cnt_ff == scgcf_pkg::CMD_BIT_LAST) begin
         cmd_port.cmd_byte <= {sdio_in, shift_ff[7:1]};
         cmd_port.cmd_toggle <= ~cmd_port.cmd_toggle;
      end
   end

endmodule : scgcf_cmd_link

// ==== hdl/scgcf_pkg.sv ====
// Shared constants, state type and decode helpers for the supervisor front end
package scgcf_pkg;

   // Core clock rate in kHz, so that a time in ms times this gives cycles
   localparam int unsigned CLK_FREQ_KHZ = 100000;
   localparam int CNT_W = 32;

   // Reset hold after supply return or pushbutton, and power-up lockout
   localparam int unsigned HOLD_TIME_MS = 250;
   localparam int unsigned HOLD_CYCLES = HOLD_TIME_MS * CLK_FREQ_KHZ;

   // Watchdog period; no figure is fixed for it, so it is a plain default
   localparam int unsigned WDOG_TIME_MS = 1600;
   localparam int unsigned WDOG_CYCLES = WDOG_TIME_MS * CLK_FREQ_KHZ;

   // Pushbutton debounce time on the reset pin
   localparam int unsigned DEBOUNCE_TIME_MS = 10;
   localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_TIME_MS * CLK_FREQ_KHZ;

   // Command byte layout
   localparam int CMD_W = 8;
   localparam int CMD_ADDR_W = 7;
   localparam int CMD_DIR_BIT = 7;
   localparam logic CMD_DIR_WRITE = 1'b1;
   localparam logic [3:0] CMD_BIT_LAST = 4'h7;
   localparam logic [3:0] CMD_BIT_DONE = 4'h8;

   // Alarm register window, any access to it clears the alarm flag
   localparam logic [6:0] ALARM_ADDR_FIRST = 7'h07;
   localparam logic [6:0] ALARM_ADDR_LAST = 7'h0A;

   // Supervisor states
   typedef enum logic [2:0] {
      SUP_FAIL = 3'b001,
      SUP_HOLD = 3'b010,
      SUP_RUN = 3'b100
   } scgcf_sup_state_type;

   // True when an address falls into the alarm register window
   function automatic logic scgcf_is_alarm_addr(input logic [6:0] addr);
      scgcf_is_alarm_addr = (addr >= ALARM_ADDR_FIRST) && (addr <= ALARM_ADDR_LAST);
   endfunction : scgcf_is_alarm_addr

endpackage : scgcf_pkg

// ==== hdl/scgcf_supervisor.sv ====
// Supervisor top: reset generation, watchdog, RAM enable gating, alarm interrupt
`timescale 1ns/100ps
module scgcf_supervisor #(
   parameter int unsigned HOLD_CYCLES = scgcf_pkg::HOLD_CYCLES,
   parameter int unsigned WDOG_CYCLES = scgcf_pkg::WDOG_CYCLES,
   parameter int unsigned DEBOUNCE_CYCLES = scgcf_pkg::DEBOUNCE_CYCLES
) (
   // Core clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Serial link
   input wire logic sclk,
   input wire logic cs_in,
   input wire logic sdio_in,
   // Supply monitor
   input wire logic power_fail_in,
   // Reset pin, open drain
   input wire logic rst_pin_in,
   output logic rst_pin_out,
   output logic rst_pin_oe,
   // Watchdog
   input wire logic watchdog_kick_n,
   // External RAM enables
   input wire logic ram_enable_in_n,
   input wire logic low_byte_select_in_n,
   input wire logic high_byte_select_in_n,
   output logic low_byte_ram_enable_out_n,
   output logic high_byte_ram_enable_out_n,
   // Alarm and interrupt
   input wire logic alarm_match_in,
   input wire logic alarm_irq_enable_in,
   output logic irq_out,
   output logic alarm_flag,
   // Decoded command to the register side
   output logic cmd_valid,
   output logic cmd_reject,
   output logic cmd_write,
   output logic [6:0] cmd_addr,
   output logic access_ready,
   output logic link_active
);

   localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYCLES - 1);
   localparam logic [31:0] WDOG_LAST = 32'(WDOG_CYCLES - 1);
   localparam logic [31:0] DEB_LAST = 32'(DEBOUNCE_CYCLES - 1);

   scgcf_cmd_if cmd_link ();

   scgcf_pkg::scgcf_sup_state_type state_ff;
   scgcf_pkg::scgcf_sup_state_type nxt_state;
   logic [scgcf_pkg::CNT_W-1:0] hold_cnt_ff;
   logic [scgcf_pkg::CNT_W-1:0] wdog_cnt_ff;
   logic [scgcf_pkg::CNT_W-1:0] btn_cnt_ff;
   logic [scgcf_pkg::CNT_W-1:0] low_len_ff;
   logic fail_s;
   logic rst_pin_s;
   logic kick_s;
   logic cs_s;
   logic toggle_s;
   logic kick_d_ff;
   logic toggle_d_ff;
   logic rst_drive_ff;
   logic access_ok_ff;
   logic ram_block_ff;
   logic kick_edge;
   logic wdog_expire;
   logic btn_low;
   logic btn_press;
   logic cmd_arrive;
   logic cmd_accept;
   logic alarm_access;

   // Serial command capture on the link clock
   scgcf_cmd_link u_link (
      .sclk(sclk),
      .rst_b(rst_b),
      .cs_in(cs_in),
      .sdio_in(sdio_in),
      .cmd_port(cmd_link.link)
   );

   scgcf_sync #(.WIDTH(4), .RESET_VAL(4'hA)) u_pin_sync ( // Reset levels: fail set, pin low, kick high, select low
      .clk(ref_clk),
      .rst_b(rst_b),
      .d({power_fail_in, rst_pin_in, watchdog_kick_n, cs_in}),
      .q({fail_s, rst_pin_s, kick_s, cs_s})
   );

   // Command toggle crosses as a level, the byte is stable by then
   scgcf_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_toggle_sync (
      .clk(ref_clk),
      .rst_b(rst_b),
      .d(cmd_link.cmd_toggle),
      .q(toggle_s)
   );

   // Edge detectors read only the second synchroniser stage
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         kick_d_ff <= 1'b1;
         toggle_d_ff <= 1'b0;
      end else begin
         kick_d_ff <= kick_s;
         toggle_d_ff <= toggle_s;
      end
   end

   // inputs ignored early
   // Kick and button count only once the power-up lockout is over
   assign kick_edge = access_ok_ff & kick_d_ff & ~kick_s;
   // Pin reads low while we drive it, so look only when released
   assign btn_low = access_ok_ff & ~rst_drive_ff & ~rst_pin_s;
   assign btn_press = btn_low && (btn_cnt_ff == DEB_LAST);
   assign cmd_arrive = toggle_s ^ toggle_d_ff;

   assign wdog_expire = (state_ff == scgcf_pkg::SUP_RUN) && (wdog_cnt_ff == WDOG_LAST)
      && !kick_edge;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         scgcf_pkg::SUP_FAIL: begin
            if (!fail_s) begin
               nxt_state = scgcf_pkg::SUP_HOLD;
            end
         end
         scgcf_pkg::SUP_HOLD: begin
            if (fail_s) begin
               nxt_state = scgcf_pkg::SUP_FAIL;
            end else if (hold_cnt_ff == HOLD_LAST) begin
               nxt_state = scgcf_pkg::SUP_RUN;
            end
         end
         scgcf_pkg::SUP_RUN: begin
            if (fail_s) begin
               nxt_state = scgcf_pkg::SUP_FAIL;
            end else if (wdog_expire || btn_press) begin
               nxt_state = scgcf_pkg::SUP_HOLD;
            end
         end
         default: begin
            nxt_state = scgcf_pkg::SUP_FAIL;
         end
      endcase
   end

   // Start in fail so the supply must be seen valid before the hold runs
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= scgcf_pkg::SUP_FAIL;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // hold after supply
   // Same hold serves supply return, watchdog and button
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_cnt_ff <= 32'h0;
      end else if (nxt_state != scgcf_pkg::SUP_HOLD || state_ff != scgcf_pkg::SUP_HOLD) begin
         hold_cnt_ff <= 32'h0;
      end else begin
         hold_cnt_ff <= hold_cnt_ff + 32'h1;
      end
   end

   // watchdog counter
   // Restarts on each kick; frozen at zero whenever reset is active
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wdog_cnt_ff <= 32'h0;
      end else if (state_ff != scgcf_pkg::SUP_RUN || kick_edge || wdog_expire) begin
         wdog_cnt_ff <= 32'h0;
      end else begin
         wdog_cnt_ff <= wdog_cnt_ff + 32'h1;
      end
   end

   // button debounce
   // Any bounce high restarts the count
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         btn_cnt_ff <= 32'h0;
      end else if (!btn_low || btn_press) begin
         btn_cnt_ff <= 32'h0;
      end else begin
         btn_cnt_ff <= btn_cnt_ff + 32'h1;
      end
   end

   // open drain reset
   // Data stays low, only the enable moves
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_drive_ff <= 1'b1;
         rst_pin_out <= 1'b0;
      end else begin
         rst_drive_ff <= (nxt_state != scgcf_pkg::SUP_RUN);
         rst_pin_out <= 1'b0;
      end
   end
   assign rst_pin_oe = rst_drive_ff;

   // power-up lockout
   // Cleared by a supply fail, set once the first hold completes
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         access_ok_ff <= 1'b0;
      end else if (fail_s) begin
         access_ok_ff <= 1'b0;
      end else if (state_ff == scgcf_pkg::SUP_HOLD && hold_cnt_ff == HOLD_LAST) begin
         access_ok_ff <= 1'b1;
      end
   end
   assign access_ready = access_ok_ff;

   // RAM stays deselected through a supply fail to protect its contents
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ram_block_ff <= 1'b1;
      end else begin
         ram_block_ff <= fail_s;
      end
   end

   // low and high byte gates
   // Kept combinational so the RAM sees no added clock latency
   assign low_byte_ram_enable_out_n = ram_enable_in_n | low_byte_select_in_n | ram_block_ff;
   assign high_byte_ram_enable_out_n = ram_enable_in_n | high_byte_select_in_n | ram_block_ff;

   assign cmd_accept = cmd_arrive & access_ok_ff & ~fail_s;

   // decode direction
   // Address and direction latched together with the valid pulse
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_valid <= 1'b0;
         cmd_reject <= 1'b0;
         cmd_write <= 1'b0;
         cmd_addr <= 7'h00;
      end else begin
         cmd_valid <= cmd_accept;
         cmd_reject <= cmd_arrive & ~cmd_accept;
         if (cmd_accept) begin
            cmd_write <= (cmd_link.cmd_byte[scgcf_pkg::CMD_DIR_BIT] == scgcf_pkg::CMD_DIR_WRITE);
            cmd_addr <= cmd_link.cmd_byte[scgcf_pkg::CMD_ADDR_W-1:0];
         end
      end
   end

   // Frame indicator from synchronised chip select
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         link_active <= 1'b0;
      end else begin
         link_active <= cs_s;
      end
   end

   assign alarm_access = cmd_accept & scgcf_pkg::scgcf_is_alarm_addr(
      cmd_link.cmd_byte[scgcf_pkg::CMD_ADDR_W-1:0]);

   // A new match wins over a clear in the same cycle
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         alarm_flag <= 1'b0;
      end else if (alarm_match_in) begin
         alarm_flag <= 1'b1;
      end else if (alarm_access) begin
         alarm_flag <= 1'b0;
      end
   end

   // no supply gating
   // Not tied to the supply state, so it keeps working on backup
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= alarm_flag & alarm_irq_enable_in;
      end
   end

   // Helper: length of the current reset pulse
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         low_len_ff <= 32'h0;
      end else if (rst_drive_ff) begin
         low_len_ff <= low_len_ff + 32'h1;
      end else begin
         low_len_ff <= 32'h0;
      end
   end

   a_low_ce_gate: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      !low_byte_ram_enable_out_n |-> (!ram_enable_in_n && !low_byte_select_in_n))
      else $error("low byte enable active without both inputs low");

   a_high_ce_gate: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      !high_byte_ram_enable_out_n |-> (!ram_enable_in_n && !high_byte_select_in_n))
      else $error("high byte enable active without both inputs low");

   a_irq_follows_flag: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (alarm_flag && alarm_irq_enable_in) [*2] |-> irq_out)
      else $error("interrupt low while flag and enable set");

   a_rst_drain_only: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      rst_pin_oe |-> !rst_pin_out)
      else $error("reset pin driven high");

   a_fail_holds_rst: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      fail_s |=> (rst_pin_oe && !cmd_valid))
      else $error("reset released or access taken during supply fail");

   a_lockout_no_cmd: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      !access_ok_ff |=> !cmd_valid)
      else $error("command taken during power-up lockout");

   a_rst_min_hold: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      $fell(rst_drive_ff) |-> (low_len_ff >= HOLD_CYCLES))
      else $error("reset pulse shorter than hold time");

   a_wdog_expiry: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      wdog_expire |=> (state_ff == scgcf_pkg::SUP_HOLD && rst_pin_oe))
      else $error("watchdog expiry did not start reset");

   a_alarm_clear: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (alarm_access && !alarm_match_in) |=> !alarm_flag ##1 !irq_out)
      else $error("alarm access did not clear flag");

endmodule : scgcf_supervisor

// ==== hdl/scgcf_sync.sv ====
// Two-flop level synchroniser, one per bit
`timescale 1ns/100ps
module scgcf_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_ff;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end

endmodule : scgcf_sync

// ==== verification/scgcf_host_model.sv ====
// Host side model: serial command sender and the pulled-up reset wire
`timescale 1ns/100ps
module scgcf_host_model (
   // Pushbutton and reset wire
   input wire logic button_n,
   input wire logic rst_pin_out,
   input wire logic rst_pin_oe,
   output logic rst_pin_in,
   // Serial pins
   output logic sclk,
   output logic cs_in,
   output logic sdio_in
);
   // open drain wire
   // Pull-up wins unless the device or the button pulls the wire low
   assign rst_pin_in = ((rst_pin_oe === 1'b1) ? rst_pin_out : 1'b1) & button_n;

   // Idle link: select low, clock parked
   initial begin
      sclk = 1'b0;
      cs_in = 1'b0;
      sdio_in = 1'b0;
   end

   // command framing
   // Select held over the whole frame, lsb first, clock still between frames
   task automatic send_byte(input logic [7:0] b);
      #3;
      cs_in = 1'b1;
      for (int i = 0; i < 8; i++) begin
         sdio_in = b[i];
         #16 sclk = 1'b1;
         #16 sclk = 1'b0;
      end
      #16 cs_in = 1'b0;
      // Released line shows the inverse so a stale bit cannot pass
      sdio_in = ~b[7];
   endtask : send_byte
endmodule : scgcf_host_model

// ==== verification/testbench.sv ====
// Self-checking bench for the supervisor front end
`timescale 1ns/100ps
module testbench;
   // Short counts so the run stays brief
   localparam int unsigned HOLD_P = 50;
   localparam int unsigned WDOG_P = 200;
   localparam int unsigned DEB_P = 8;
   logic ref_clk, rst_b, sclk, cs_in, sdio_in, power_fail_in, rst_pin_in, button_n;
   logic rst_pin_out, rst_pin_oe, watchdog_kick_n, ram_enable_in_n, low_byte_select_in_n;
   logic high_byte_select_in_n, low_byte_ram_enable_out_n, high_byte_ram_enable_out_n;
   logic alarm_match_in, alarm_irq_enable_in, irq_out, alarm_flag, kick_en;
   logic cmd_valid, cmd_reject, cmd_write, access_ready, link_active;
   logic [6:0] cmd_addr;
   logic [7:0] cb;
   logic [8:0] exp_q[$];
   int failures, num_checks, seed;
   time t0;

   scgcf_supervisor #(.HOLD_CYCLES(HOLD_P), .WDOG_CYCLES(WDOG_P), .DEBOUNCE_CYCLES(DEB_P))
   scgcf_supervisor_inst (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_in(cs_in),
      .sdio_in(sdio_in), .power_fail_in(power_fail_in), .rst_pin_in(rst_pin_in),
      .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .watchdog_kick_n(watchdog_kick_n),
      .ram_enable_in_n(ram_enable_in_n), .low_byte_select_in_n(low_byte_select_in_n),
      .high_byte_select_in_n(high_byte_select_in_n),
      .low_byte_ram_enable_out_n(low_byte_ram_enable_out_n),
      .high_byte_ram_enable_out_n(high_byte_ram_enable_out_n),
      .alarm_match_in(alarm_match_in), .alarm_irq_enable_in(alarm_irq_enable_in),
      .irq_out(irq_out), .alarm_flag(alarm_flag), .cmd_valid(cmd_valid),
      .cmd_reject(cmd_reject), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
      .access_ready(access_ready), .link_active(link_active));

   scgcf_host_model scgcf_host_model_inst (.button_n(button_n), .rst_pin_out(rst_pin_out),
      .rst_pin_oe(rst_pin_oe), .rst_pin_in(rst_pin_in), .sclk(sclk), .cs_in(cs_in),
      .sdio_in(sdio_in));

   // Core clock, 10 ns
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("Checks %0d, failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run

   // Bounded wait for a level on the reset pull-down enable
   task automatic wait_oe(input logic lvl, input int lim);
      int cyc;
      cyc = 0;
      while (rst_pin_oe !== lvl) begin
         @(negedge ref_clk);
         cyc++;
         if (cyc > lim) begin
            failures++;
            $display("MISMATCH at %0t: reset enable wait ran out", $time);
            complete_run();
         end
      end
   endtask : wait_oe

   // Cycles since t0 must fall within lo..hi
   task automatic span(input int lo, input int hi);
      check(9'((($time - t0) / 10 >= lo) && (($time - t0) / 10 <= hi)), 9'h001, "span");
   endtask : span

   // Note the expected outcome, then send the byte
   task automatic command(input logic [7:0] b, input logic rej);
      exp_q.push_back(rej ? 9'h100 : {1'b0, b});
      scgcf_host_model_inst.send_byte(b);
      repeat (12) @(negedge ref_clk);
   endtask : command

   // Watcher: each command pulse takes the oldest note
   // Looked at mid-cycle, so a pulse is seen once and settled
   always @(negedge ref_clk) begin
      if (cmd_valid === 1'b1 || cmd_reject === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(9'h1FF, 9'h000, "unexpected command");
         end else begin
            check(cmd_reject ? 9'h100 : {1'b0, cmd_write, cmd_addr}, exp_q.pop_front(),
               "command");
         end
         check(9'(link_active), 9'h001, "frame seen");
      end
   end

   // periodic kick
   // Kicks well inside the watchdog period while enabled
   always begin
      @(negedge ref_clk);
      if (kick_en) begin
         repeat (40) @(negedge ref_clk);
         watchdog_kick_n = 1'b0;
         repeat (4) @(negedge ref_clk);
         watchdog_kick_n = 1'b1;
      end
   end

   // Hang guard
   initial begin
      #300000;
      failures++;
      complete_run();
   end

   // Main sequence
   initial begin
      seed = 42551;
      failures = 0;
      num_checks = 0;
      rst_b = 1'b0;
      power_fail_in = 1'b0;
      button_n = 1'b1;
      watchdog_kick_n = 1'b1;
      kick_en = 1'b0;
      ram_enable_in_n = 1'b1;
      low_byte_select_in_n = 1'b1;
      high_byte_select_in_n = 1'b1;
      alarm_match_in = 1'b0;
      alarm_irq_enable_in = 1'b0;
      repeat (20) @(negedge ref_clk);
      check(9'({rst_pin_oe, rst_pin_out}), 9'h002, "reset pulled in reset");
      rst_b = 1'b1;
      t0 = $time;
      command(8'h85, 1'b1);
      wait_oe(1'b0, HOLD_P + 20);
      span(HOLD_P, HOLD_P + 8);
      repeat (2) @(negedge ref_clk);
      check(9'(access_ready), 9'h001, "ready after lockout");
      kick_en = 1'b1;
      for (int i = 0; i < 16; i++) begin
         {ram_enable_in_n, low_byte_select_in_n, high_byte_select_in_n} = 3'($random(seed));
         #1;
         check(9'({low_byte_ram_enable_out_n, high_byte_ram_enable_out_n}),
            9'({ram_enable_in_n | low_byte_select_in_n,
            ram_enable_in_n | high_byte_select_in_n}), "byte enables");
         @(negedge ref_clk);
      end
      // Random commands, both directions
      for (int i = 0; i < 8; i++) begin
         cb = {i[0], 7'($random(seed))};
         command(cb, 1'b0);
      end
      // Alarm flag, interrupt and clearing access
      alarm_irq_enable_in = 1'b1;
      alarm_match_in = 1'b1;
      @(negedge ref_clk);
      alarm_match_in = 1'b0;
      check(9'(alarm_flag), 9'h001, "alarm flag set");
      @(negedge ref_clk);
      check(9'(irq_out), 9'h001, "irq raised");
      command(8'h8B, 1'b0);
      check(9'({alarm_flag, irq_out}), 9'h003, "irq holds");
      alarm_irq_enable_in = 1'b0;
      repeat (2) @(negedge ref_clk);
      check(9'(irq_out), 9'h000, "irq masked");
      alarm_irq_enable_in = 1'b1;
      command(8'h0A, 1'b0);
      check(9'({alarm_flag, irq_out}), 9'h000, "alarm cleared");
      // Short glitch on the button is ignored
      button_n = 1'b0;
      repeat (3) @(negedge ref_clk);
      button_n = 1'b1;
      repeat (20) @(negedge ref_clk);
      check(9'(rst_pin_oe), 9'h000, "glitch ignored");
      // Held button gives a full reset pulse, timed from the pull-down itself
      button_n = 1'b0;
      t0 = $time;
      wait_oe(1'b1, DEB_P + 10);
      span(DEB_P, DEB_P + 4);
      t0 = $time;
      button_n = 1'b1;
      wait_oe(1'b0, HOLD_P + 20);
      span(HOLD_P, HOLD_P + 4);
      // Watchdog expiry after the last kick
      kick_en = 1'b0;
      repeat (50) @(negedge ref_clk);
      watchdog_kick_n = 1'b0;
      t0 = $time;
      repeat (4) @(negedge ref_clk);
      watchdog_kick_n = 1'b1;
      wait_oe(1'b1, WDOG_P + 20);
      span(WDOG_P, WDOG_P + 8);
      check(9'(rst_pin_out), 9'h000, "drives low only");
      wait_oe(1'b0, HOLD_P + 20);
      kick_en = 1'b1;
      // Supply fail: reset, refusal and blocked RAM enables
      power_fail_in = 1'b1;
      ram_enable_in_n = 1'b0;
      low_byte_select_in_n = 1'b0;
      high_byte_select_in_n = 1'b0;
      wait_oe(1'b1, 6);
      command(8'h81, 1'b1);
      check(9'({low_byte_ram_enable_out_n, high_byte_ram_enable_out_n}), 9'h003,
         "ram blocked in fail");
      power_fail_in = 1'b0;
      t0 = $time;
      wait_oe(1'b0, HOLD_P + 20);
      span(HOLD_P, HOLD_P + 8);
      check(9'(access_ready), 9'h001, "ready after fail");
      repeat (10) @(negedge ref_clk);
      check(9'(exp_q.size()), 9'h000, "all commands seen");
      check(9'(link_active), 9'h000, "link idle");
      complete_run();
   end
endmodule : testbench
